// ---- include/mode_page_regs.svh ----
`ifndef MODE_PAGE_REGS_SVH
`define MODE_PAGE_REGS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CTRL_PAGE   8'h00
`define OFS_DCFG_DELAY  8'h04
`define OFS_DCFG_FLAGS  8'h08
`define OFS_COMP_CTRL   8'h0C
`define OFS_COMP_ALGO   8'h10
`define OFS_DISC_PAGE   8'h14
`define OFS_DISC_EFF    8'h18
`define OFS_PART_PAGE   8'h1C
`define OFS_ERR_PAGE    8'h20
`define OFS_STATUS      8'h24

// ****************************************************************
// page codes and lengths
// ****************************************************************
`define CODE_CTRL       8'h0A
`define LEN_CTRL        8'h06
`define CODE_DCFG       8'h10
`define LEN_DCFG        8'h0E
`define CODE_COMP       8'h0F
`define LEN_COMP        8'h0E
`define ALGO_LZ         8'h10
`define MEDIUM_AUTO_FMT 8'h01

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_LOG_EXC     0
`define BIT_BIS         5
`define BIT_EEG         8
`define BIT_SEW         9
`define BIT_SEL_COMP    16
`define BIT_RUR         17
`define BIT_DCE         15
`define BIT_DCC         14
`define BIT_DDE         7
`define BIT_EER         3
`define BIT_PER         2
`define BIT_ST_REJECT   0

// ****************************************************************
// reset values, limits, sense keys
// ****************************************************************
`define WDELAY_DEFAULT  16'h00C8
`define WDELAY_MIN      16'h000F
`define WDELAY_MAX      16'h1964
`define BURST_DEFAULT   16'h0080
`define BURST_ALIGN     17'h00008
`define SENSE_UNIT_ATTN 4'h6
`define SENSE_RECOVERED 4'h1
`define RESP_OKAY       2'h0
`define RESP_DECERR     2'h3

// ****************************************************************
// timing
// ****************************************************************
`define WDELAY_UNIT_MS  100
`define CLK_KHZ         100000
`define TICK_CYCLES     (`WDELAY_UNIT_MS * `CLK_KHZ)

`endif

// ---- include/mode_page_pkg.sv ----
package mode_page_pkg;

	// eod sequencing before a direction change
	typedef enum logic [2:0]
	{
		EOD_IDLE = 3'b001,
		EOD_MARK = 3'b010,
		EOD_TURN = 3'b100
	} eod_state_t;

	// whole state of the responder
	typedef struct packed
	{
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        log_exception_report;
		logic [15:0] write_delay;
		logic        sel_comp;
		logic        report_uncompressed_read;
		logic [15:0] burst;
		logic [1:0]  disconnect_control;
		logic        post_error;
		logic        ua_pend;
		logic        rec_pend;
		logic        reject;
		logic        check_condition;
		logic [3:0]  sense_key;
		logic        wrote;
		eod_state_t  eod;
		logic        write_eod;
		logic        dir_go;
		logic        flush_req;
	} core_state_t;

	// state of the flush timer
	typedef struct packed
	{
		logic [31:0] ticks;
		logic [15:0] units;
		logic        expired;
	} flush_state_t;

endpackage

// ---- core/write_flush_timer.sv ----
`timescale 1ns/1ps
`include "mode_page_regs.svh"

module write_flush_timer
	import mode_page_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        restart,
	input  wire logic [15:0] delay_units,
	output logic             expired
);

	flush_state_t st_ff;
	flush_state_t nxt_st;

	// ****************************************************************
	// tick and unit counting
	// ****************************************************************
	// counts whole 100 ms units; a restart clears any partial unit too, so
	// the flush comes one cycle after a whole delay from the restart, never early
	always_comb
	begin
		nxt_st         = st_ff;
		nxt_st.expired = 1'b0;
		if (restart)
		begin
			nxt_st.ticks = 32'h0000_0000;
			nxt_st.units = 16'h0000;
		end
		else if (st_ff.ticks == 32'(TICK_CYCLES - 1))
		begin
			nxt_st.ticks = 32'h0000_0000;
			if (st_ff.units + 16'h0001 >= delay_units)
			begin
				nxt_st.units   = 16'h0000;
				nxt_st.expired = 1'b1;
			end
			else
			begin
				nxt_st.units = st_ff.units + 16'h0001;
			end
		end
		else
		begin
			nxt_st.ticks = st_ff.ticks + 32'h0000_0001;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign expired = st_ff.expired;

endmodule // write_flush_timer

// ---- core/tape_mode_page_responder.sv ----
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "mode_page_regs.svh"

//Function
// - log_exception_report set: threshold hit ends command with unit attention 6h.
// - control page queue, allegiance, event and holdoff fields read zero.
// - config page savable, change partition/format, active format zero; partition 0.
// - buffer ratio fields read zero; restart thresholds adapt to host rate.
// - flush partial write buffer within write delay in 100 ms units.
// - write delay resets to C8h, accepts only Fh through 1964h.
// - byte 8: block_ids_supported 1, other listed flags 0.
// - gap size and end-of-data-defined fields read zero.
// - end_of_data_generation reads 1; eod mark before reversal after writes.
// - sync_at_early_warning reads 1; buffer-size-at-early-warning reads zero.
// - select compression one enables compression, zero disables it.
// - compression page code 0Fh, length 0Eh, savable_flag zero.
// - compression_capable 1; compression follows compression_enable byte 2 bit 7.
// - decompression_enable reads 1; tape data decompressed automatically.
// - no boundary exceptions; report_decompression_exception reads 00h.
// - compression algorithm field reads 10h.
// - decompression algorithm 10h, zero when uncompressed-read report applies.
// - burst limit in 512-byte units, zero unlimited, rounded up to 8s.
// - partition page counts, partition flags and size unit read zero.
// - medium format recognition reads 01h.
// - early recovery always on; transfer block, no-transfer, no-correction zero.
// - post_error reports recovered errors with check condition; default off.
// - control page code 0Ah, length 06h.
module tape_mode_page_responder
	import mode_page_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        bus_reset,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        err_threshold_hit,
	input  wire logic        recovered_error,
	input  wire logic        cmd_end,
	output logic             check_condition,
	output logic [3:0]       sense_key,
	input  wire logic        wbuf_pending,
	input  wire logic        wbuf_threshold_hit,
	output logic             flush_req,
	input  wire logic        write_op,
	input  wire logic        dir_change_req,
	output logic             write_eod,
	output logic             dir_go,
	output logic             eod_busy,
	output logic             compress_en,
	output logic             decompress_en,
	input  wire logic        last_block_uncompressed,
	output logic [16:0]      burst_limit,
	output logic [1:0]       disconnect_control
);

	core_state_t st_ff;
	core_state_t nxt_st;
	logic        timer_expired;
	logic        wr_fire;
	logic        rd_fire;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = new_w[i*8 +: 8];
		end
		return res;
	endfunction

	// round a burst size up to a multiple of eight units; zero stays zero
	function automatic logic [16:0] round_burst(input logic [15:0] b);
		logic [16:0] sum;
		sum = {1'b0, b} + (`BURST_ALIGN - 17'h00001);
		return sum & ~(`BURST_ALIGN - 17'h00001);
	endfunction

	// defaults of every changeable field
	function automatic core_state_t defaults(input core_state_t s);
		core_state_t d;
		d                          = s;
		d.log_exception_report     = 1'b0;
		d.write_delay              = `WDELAY_DEFAULT;
		d.sel_comp                 = 1'b1;
		d.report_uncompressed_read = 1'b0;
		d.burst                    = `BURST_DEFAULT;
		d.disconnect_control       = 2'h0;
		d.post_error               = 1'b0;
		return d;
	endfunction

	// ****************************************************************
	// read decode
	// ****************************************************************
	function automatic logic [31:0] read_word(input core_state_t s,
		input logic [7:0] addr, input logic uncompressed, input logic busy);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (addr)
			`OFS_CTRL_PAGE:
			begin
				w[31:24]           = `CODE_CTRL;
				w[23:16]           = `LEN_CTRL;
				w[`BIT_LOG_EXC]    = s.log_exception_report;
			end
			`OFS_DCFG_DELAY:
			begin
				w[31:24] = `CODE_DCFG;
				w[23:16] = `LEN_DCFG;
				w[15:0]  = s.write_delay;
			end
			`OFS_DCFG_FLAGS:
			begin
				w[`BIT_BIS]      = 1'b1;
				w[`BIT_EEG]      = 1'b1;
				w[`BIT_SEW]      = 1'b1;
				w[`BIT_SEL_COMP] = s.sel_comp;
				w[`BIT_RUR]      = s.report_uncompressed_read;
			end
			`OFS_COMP_CTRL:
			begin
				w[31:24]    = `CODE_COMP;
				w[23:16]    = `LEN_COMP;
				w[`BIT_DCE] = s.sel_comp;
				w[`BIT_DCC] = 1'b1;
				w[`BIT_DDE] = 1'b1;
			end
			`OFS_COMP_ALGO:
			begin
				w[15:8] = `ALGO_LZ;
				w[7:0]  = (s.report_uncompressed_read && uncompressed)
					? 8'h00 : `ALGO_LZ;
			end
			`OFS_DISC_PAGE:
			begin
				w[15:0]  = s.burst;
				w[17:16] = s.disconnect_control;
			end
			`OFS_DISC_EFF:
				w[16:0] = round_burst(s.burst);
			`OFS_PART_PAGE:
				w[7:0] = `MEDIUM_AUTO_FMT;
			`OFS_ERR_PAGE:
			begin
				w[`BIT_EER] = 1'b1;
				w[`BIT_PER] = s.post_error;
			end
			`OFS_STATUS:
			begin
				w[`BIT_ST_REJECT] = s.reject;
				w[1]              = s.ua_pend;
				w[2]              = s.rec_pend;
				w[3]              = busy;
			end
			default:
				w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		return (addr[1:0] == 2'b00) && (addr <= `OFS_STATUS);
	endfunction

	// ****************************************************************
	// bus handshakes
	// ****************************************************************
	// address and data are taken together; one write response at a time
	assign awready = awvalid && wvalid && !st_ff.bvalid;
	assign wready  = awready;
	assign arready = !st_ff.rvalid;
	assign wr_fire = awvalid && wvalid && !st_ff.bvalid;
	assign rd_fire = arvalid && !st_ff.rvalid;

	// ****************************************************************
	// flush timer
	// ****************************************************************
	// restarts whenever the buffer is empty or has just been flushed
	write_flush_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) i_write_flush_timer (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.restart     (!wbuf_pending || st_ff.flush_req),
		.delay_units (st_ff.write_delay),
		.expired     (timer_expired)
	);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		logic [31:0] cur;
		logic [31:0] nw;
		logic        ua_now;
		logic        rec_now;
		cur    = 32'h0000_0000;
		nw     = 32'h0000_0000;
		ua_now = 1'b0;
		rec_now = 1'b0;
		nxt_st = st_ff;

		// response channels
		if (st_ff.bvalid && bready)
			nxt_st.bvalid = 1'b0;
		if (st_ff.rvalid && rready)
			nxt_st.rvalid = 1'b0;

		if (rd_fire)
		begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp  = mapped(araddr) ? `RESP_OKAY : `RESP_DECERR;
			nxt_st.rdata  = read_word(st_ff, araddr, last_block_uncompressed,
				st_ff.eod != EOD_IDLE);
		end

		// register writes
		if (wr_fire)
		begin
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = mapped(awaddr) ? `RESP_OKAY : `RESP_DECERR;
			cur = read_word(st_ff, awaddr, last_block_uncompressed,
				st_ff.eod != EOD_IDLE);
			nw  = merge(cur, wdata, wstrb);
			case (awaddr)
				`OFS_CTRL_PAGE:
					nxt_st.log_exception_report = nw[`BIT_LOG_EXC];
				`OFS_DCFG_DELAY:
				begin
					// out-of-range values are dropped, old value kept
					if (nw[15:0] >= `WDELAY_MIN && nw[15:0] <= `WDELAY_MAX)
						nxt_st.write_delay = nw[15:0];
					else
						nxt_st.reject = 1'b1;
				end
				`OFS_DCFG_FLAGS:
				begin
					nxt_st.sel_comp                 = nw[`BIT_SEL_COMP];
					nxt_st.report_uncompressed_read = nw[`BIT_RUR];
				end
				`OFS_COMP_CTRL:
					nxt_st.sel_comp = nw[`BIT_DCE];
				`OFS_DISC_PAGE:
				begin
					nxt_st.burst              = nw[15:0];
					nxt_st.disconnect_control = nw[17:16];
				end
				`OFS_ERR_PAGE:
					nxt_st.post_error = nw[`BIT_PER];
				`OFS_STATUS:
				begin
					// write one to clear the rejected-delay flag
					if (wstrb[0] && wdata[`BIT_ST_REJECT])
						nxt_st.reject = 1'b0;
				end
				default:
					nxt_st.reject = nxt_st.reject;
			endcase
		end

		// a rejection in this cycle wins over the clear
		if (wr_fire && awaddr == `OFS_DCFG_DELAY && !(nw[15:0] >= `WDELAY_MIN
			&& nw[15:0] <= `WDELAY_MAX))
			nxt_st.reject = 1'b1;

		// ************************************************************
		// check condition reporting
		// ************************************************************
		// an event in the ending cycle is folded in, never lost
		ua_now  = st_ff.ua_pend || (err_threshold_hit && st_ff.log_exception_report);
		rec_now = st_ff.rec_pend || (recovered_error && st_ff.post_error);
		nxt_st.ua_pend         = ua_now;
		nxt_st.rec_pend        = rec_now;
		nxt_st.check_condition = 1'b0;
		if (cmd_end)
		begin
			// unit attention outranks a recovered error
			if (ua_now)
			begin
				nxt_st.check_condition = 1'b1;
				nxt_st.sense_key       = `SENSE_UNIT_ATTN;
				nxt_st.ua_pend         = 1'b0;
			end
			else if (rec_now)
			begin
				nxt_st.check_condition = 1'b1;
				nxt_st.sense_key       = `SENSE_RECOVERED;
				nxt_st.rec_pend        = 1'b0;
			end
		end

		// write buffer flush: threshold early, timer at the latest
		nxt_st.flush_req = wbuf_pending && !st_ff.flush_req
			&& (wbuf_threshold_hit || timer_expired);

		// ************************************************************
		// end-of-data before a direction change
		// ************************************************************
		nxt_st.write_eod = 1'b0;
		nxt_st.dir_go    = 1'b0;
		if (write_op)
			nxt_st.wrote = 1'b1;
		case (st_ff.eod)
			EOD_IDLE:
			begin
				if (dir_change_req && (st_ff.wrote || write_op))
				begin
					nxt_st.eod       = EOD_MARK;
					nxt_st.write_eod = 1'b1;
					nxt_st.wrote     = 1'b0;
				end
				else if (dir_change_req)
				begin
					nxt_st.dir_go = 1'b1;
				end
			end
			EOD_MARK:
				nxt_st.eod = EOD_TURN;
			EOD_TURN:
			begin
				nxt_st.eod    = EOD_IDLE;
				nxt_st.dir_go = 1'b1;
			end
			default:
				nxt_st.eod = EOD_IDLE;
		endcase

		// bus reset restores defaults; pending events are dropped
		if (bus_reset)
		begin
			nxt_st          = defaults(nxt_st);
			nxt_st.ua_pend  = 1'b0;
			nxt_st.rec_pend = 1'b0;
			nxt_st.wrote    = 1'b0;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff     <= defaults('0);
			st_ff.eod <= EOD_IDLE;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign bvalid             = st_ff.bvalid;
	assign bresp              = st_ff.bresp;
	assign rvalid             = st_ff.rvalid;
	assign rresp              = st_ff.rresp;
	assign rdata              = st_ff.rdata;
	assign check_condition    = st_ff.check_condition;
	assign sense_key          = st_ff.sense_key;
	assign flush_req          = st_ff.flush_req;
	assign write_eod          = st_ff.write_eod;
	assign dir_go             = st_ff.dir_go;
	assign eod_busy           = st_ff.eod != EOD_IDLE;
	assign compress_en        = st_ff.sel_comp;
	assign decompress_en      = 1'b1;
	assign burst_limit        = round_burst(st_ff.burst);
	assign disconnect_control = st_ff.disconnect_control;

endmodule // tape_mode_page_responder

// ---- dv/mode_page_checker.sv ----
`timescale 1ns/1ps
module mode_page_checker
	import mode_page_pkg::*;
#(
	parameter int TICK_CYCLES = 4
)
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        bus_reset,
	input wire logic        awvalid,
	input wire logic        cmd_end,
	input wire logic        check_condition,
	input wire logic [3:0]  sense_key,
	input wire logic        wbuf_pending,
	input wire logic        flush_req,
	input wire logic        write_eod,
	input wire logic        dir_go,
	input wire logic        eod_busy,
	input wire logic        compress_en,
	input wire logic        decompress_en,
	input wire logic [16:0] burst_limit
);
	// single domain, so clock and reset are given once
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// status only answers a command end, for one cycle
	property p_cc_cause; check_condition |-> $past(cmd_end); endproperty
	a_cc_cause: assert property (p_cc_cause) else $error("status without command end");
	property p_cc_pulse; check_condition && !cmd_end |=> !check_condition; endproperty
	a_cc_pulse: assert property (p_cc_pulse) else $error("status longer than a cycle");
	property p_cc_key; check_condition |-> sense_key == 4'h6 || sense_key == 4'h1; endproperty
	a_cc_key: assert property (p_cc_key) else $error("bad sense key");
	// write port kept quiet, though a colliding write loses to the restore anyway, since defaults are applied last
	property p_bus_def; bus_reset && !awvalid |-> ##1 compress_en && burst_limit == 17'h00080;
	endproperty
	a_bus_def: assert property (p_bus_def) else $error("bus reset kept old fields");
	property p_burst_align; burst_limit[2:0] == 3'h0; endproperty
	a_burst_align: assert property (p_burst_align) else $error("burst not a multiple of 8");
	property p_decomp; decompress_en; endproperty
	a_decomp: assert property (p_decomp) else $error("decompression off");
	property p_flush_one; flush_req |=> !flush_req; endproperty
	a_flush_one: assert property (p_flush_one) else $error("flush held two cycles");
	property p_flush_src; flush_req |-> $past(wbuf_pending); endproperty
	a_flush_src: assert property (p_flush_src) else $error("flush with empty buffer");
	property p_eod_seq; write_eod |-> eod_busy ##2 dir_go; endproperty
	a_eod_seq: assert property (p_eod_seq) else $error("turn not two cycles after mark");
	property p_eod_start; $rose(eod_busy) |-> write_eod; endproperty
	a_eod_start: assert property (p_eod_start) else $error("sequence without mark");

	c_ua: cover property (check_condition && sense_key == 4'h6);
	c_eod: cover property (write_eod);
	c_flush: cover property (flush_req);
endmodule // mode_page_checker

// ---- dv/scsi_initiator_model.sv ----
`timescale 1ns/1ps
module scsi_initiator_model
	import mode_page_pkg::*;
(
	input  wire logic       aclk,
	output logic            err_threshold_hit = 1'h0,
	output logic            recovered_error = 1'h0,
	output logic            cmd_end = 1'h0,
	input  wire logic       check_condition,
	input  wire logic [3:0] sense_key
);
	// one command: events in a cycle, its end next, status seen a cycle after
	task run(input logic e, input logic r, output logic cc, output logic [3:0] k);
		@(posedge aclk);
		err_threshold_hit <= e;
		recovered_error <= r;
		@(posedge aclk);
		err_threshold_hit <= 1'h0;
		recovered_error <= 1'h0;
		cmd_end <= 1'h1;
		@(posedge aclk);
		cmd_end <= 1'h0;
		@(negedge aclk);
		cc = check_condition;
		k = sense_key;
	endtask
endmodule // scsi_initiator_model

// ---- dv/tape_mode_page_responder_test.sv ----
`timescale 1ns/1ps
module tape_mode_page_responder_test;
	localparam int TICK = 4;
	logic        aclk, awready, wready, bvalid, arready, rvalid, cmd_end, check_condition, cc;
	logic        err_threshold_hit, recovered_error, flush_req, write_eod, dir_go, eod_busy;
	logic        compress_en, decompress_en;
	logic        aresetn = 1'h0, bus_reset = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
	logic        bready = 1'h1, arvalid = 1'h0, rready = 1'h1, wbuf_pending = 1'h0;
	logic        wbuf_threshold_hit = 1'h0, write_op = 1'h0, dir_change_req = 1'h0;
	logic        last_block_uncompressed = 1'h0;
	logic [1:0]  bresp, rresp, disconnect_control;
	logic [3:0]  wstrb = 4'hF;
	logic [3:0]  sense_key, k;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [16:0] burst_limit;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	int          n_fail = 0, tests_run = 0, n;

	tape_mode_page_responder #(.TICK_CYCLES(TICK)) i_tape_mode_page_responder
	(
		.aclk, .aresetn, .bus_reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .err_threshold_hit, .recovered_error, .cmd_end, .check_condition,
		.sense_key, .wbuf_pending, .wbuf_threshold_hit, .flush_req, .write_op,
		.dir_change_req, .write_eod, .dir_go, .eod_busy, .compress_en, .decompress_en,
		.last_block_uncompressed, .burst_limit, .disconnect_control
	);
	scsi_initiator_model i_scsi_initiator_model
	(
		.aclk, .err_threshold_hit, .recovered_error, .cmd_end, .check_condition, .sense_key
	);

	initial
	begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end

	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", s, e, g);
			n_fail++;
		end
	endtask

	// handshakes judged at the falling edge, where inputs are settled
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		do @(negedge aclk); while (!awready);
		@(posedge aclk);
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		do @(negedge aclk); while (!bvalid);
		chk("bresp", 32'h0, {30'h0, bresp});
		@(negedge aclk);
	endtask

	task rc(input string s, input logic [7:0] a, input logic [31:0] e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'h0;
		do @(negedge aclk); while (!rvalid);
		chk(s, e, rdata);
		chk(s, (a == 8'h40) ? 32'h3 : 32'h0, {30'h0, rresp});
	endtask

	task t_defaults;
		rc("ctrl", 8'h00, 32'h0A060000);
		rc("delay", 8'h04, 32'h100E00C8);
		rc("flags", 8'h08, 32'h00010320);
		rc("comp", 8'h0C, 32'h0F0EC080);
		rc("algo", 8'h10, 32'h00001010);
		rc("burst", 8'h18, 32'h00000080);
		rc("part", 8'h1C, 32'h00000001);
		rc("err", 8'h20, 32'h00000008);
		rc("unmapped", 8'h40, 32'h00000000);
	endtask

	// limits of the delay, then the deadline at the smallest one
	task t_delay;
		wr(8'h04, 32'h0000000E);
		wr(8'h04, 32'h00001965);
		rc("kept", 8'h04, 32'h100E00C8);
		rc("refused", 8'h24, 32'h00000001);
		wr(8'h04, 32'h00001964);
		rc("max", 8'h04, 32'h100E1964);
		wr(8'h04, 32'h0000000F);
		@(posedge aclk);
		wbuf_pending <= 1'h1;
		n = 0;
		do
		begin
			@(negedge aclk);
			n++;
		end
		while (!flush_req && n < 200);
		chk("flush time", 32'h1, 32'(n > 14 * TICK && n <= 15 * TICK + 4));
		@(posedge aclk);
		wbuf_threshold_hit <= 1'h1;
		@(posedge aclk);
		wbuf_threshold_hit <= 1'h0;
		@(negedge aclk);
		chk("early flush", 32'h1, {31'h0, flush_req});
		@(posedge aclk);
		wbuf_pending <= 1'h0;
	endtask

	// both pending: attention first, recovered on the next command
	task t_events;
		i_scsi_initiator_model.run(1'h1, 1'h1, cc, k);
		chk("masked", 32'h0, {31'h0, cc});
		wr(8'h00, 32'h00000001);
		wr(8'h20, 32'h00000004);
		i_scsi_initiator_model.run(1'h1, 1'h1, cc, k);
		chk("attention", 32'h16, {27'h0, cc, k});
		i_scsi_initiator_model.run(1'h0, 1'h0, cc, k);
		chk("recovered", 32'h11, {27'h0, cc, k});
	endtask

	task t_comp;
		wr(8'h08, 32'h00000000);
		chk("comp off", 32'h0, {31'h0, compress_en});
		rc("dce off", 8'h0C, 32'h0F0E4080);
		wr(8'h08, 32'h00030000);
		@(posedge aclk);
		last_block_uncompressed <= 1'h1;
		rc("uncomp", 8'h10, 32'h00001000);
		@(posedge aclk);
		last_block_uncompressed <= 1'h0;
		rc("comp blk", 8'h10, 32'h00001010);
		chk("comp on", 32'h1, {31'h0, compress_en});
		wr(8'h14, 32'h00030001);
		chk("burst 1", 32'h60008, {13'h0, disconnect_control, burst_limit});
		wr(8'h14, 32'h0000FFFF);
		chk("burst max", 32'h10000, {15'h0, burst_limit});
		wr(8'h14, 32'h00000000);
		chk("no limit", 32'h0, {15'h0, burst_limit});
	endtask

	// a turn after a write gets a mark first; a plain turn does not
	task t_eod;
		@(posedge aclk);
		write_op <= 1'h1;
		@(posedge aclk);
		write_op <= 1'h0;
		dir_change_req <= 1'h1;
		@(posedge aclk);
		dir_change_req <= 1'h0;
		@(negedge aclk);
		chk("mark", 32'h1, {31'h0, write_eod});
		repeat (2) @(negedge aclk);
		chk("turn", 32'h1, {31'h0, dir_go});
		@(posedge aclk);
		dir_change_req <= 1'h1;
		@(posedge aclk);
		dir_change_req <= 1'h0;
		@(negedge aclk);
		chk("plain turn", 32'h1, {30'h0, write_eod, dir_go});
	endtask

	task t_bus_reset;
		wr(8'h04, 32'h00000100);
		@(posedge aclk);
		bus_reset <= 1'h1;
		@(posedge aclk);
		bus_reset <= 1'h0;
		rc("delay def", 8'h04, 32'h100E00C8);
		rc("flags def", 8'h08, 32'h00010320);
		rc("ctrl def", 8'h00, 32'h0A060000);
		rc("err def", 8'h20, 32'h00000008);
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		t_defaults();
		t_delay();
		t_events();
		t_comp();
		t_eod();
		t_bus_reset();
		report_and_stop();
	end

	// whole run is well under a thousand cycles
	initial
	begin
		#50000;
		n_fail++;
		report_and_stop();
	end
endmodule // tape_mode_page_responder_test

bind tape_mode_page_responder mode_page_checker #(.TICK_CYCLES(TICK_CYCLES)) i_mode_page_checker
(
	.aclk, .aresetn, .bus_reset, .awvalid, .cmd_end, .check_condition, .sense_key,
	.wbuf_pending, .flush_req, .write_eod, .dir_go, .eod_busy, .compress_en,
	.decompress_en, .burst_limit
);
